// ---- design/mss_map.vh ----
`ifndef MSS_MAP_VH
`define MSS_MAP_VH
// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define MSS_OFS_CTRL     12'h000
`define MSS_OFS_START    12'h004
`define MSS_OFS_HOLD     12'h008
`define MSS_OFS_SBRK     12'h00C
`define MSS_OFS_STOP     12'h010
`define MSS_OFS_PBRK     12'h014
`define MSS_OFS_TARGET   12'h018
`define MSS_OFS_STATUS   12'h01C
`define MSS_OFS_FREQ     12'h020
// ----------------------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------------------
`define MSS_CTRL_RUN     0
`define MSS_CTRL_JOG     1
`define MSS_CTRL_REV     2
`define MSS_START_DIRECT 2'd0
`define MSS_START_TRACK  2'd1
`define MSS_START_PREEX  2'd2
`define MSS_ORG_STOP     2'd0
`define MSS_ORG_ZERO     2'd1
`define MSS_ORG_MAX      2'd2
`define MSS_STOP_DECEL   1'b0
`define MSS_STOP_COAST   1'b1
// ----------------------------------------------------------------------------
// Reset values and write limits
// ----------------------------------------------------------------------------
`define MSS_RST_RATE     7'd20
`define MSS_RST_MAXF     16'd5000
`define MSS_RATE_MIN     7'd1
`define MSS_RATE_MAX     7'd100
`define MSS_FREQ_LIM     16'd1000
`define MSS_TIME_LIM     10'd1000
`define MSS_PCT_LIM      7'd100
// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define MSS_CLK_HZ       100000000
`define MSS_TICK_MS      100
`define MSS_TICK_CYC     (`MSS_CLK_HZ / 1000 * `MSS_TICK_MS)
`endif

// ---- design/mss_sequencer.v ----
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "mss_map.vh"
module mss_sequencer #(
  parameter TICK_CYC = `MSS_TICK_CYC
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [15:0] motor_speed_est,
  output reg  [15:0] out_freq,
  output reg         out_reverse,
  output reg         out_enable,
  output reg         dc_inject,
  output reg  [6:0]  inject_current,
  output reg         accel_enable,
  output reg         seq_time_count
);
  // --------------------------------------------------------------------------
  // Phase codes
  // --------------------------------------------------------------------------
  // The sequencer walks these phases in one direction per command. A start
  // leaves idle for start braking, pre-excitation, tracking or holding; a
  // stop leaves running for deceleration or goes straight back to idle. The
  // codes are visible in the status word, so software can see which phase
  // holds the drive while a long timed phase runs.
  localparam [3:0] PH_IDLE  = 4'd0;
  localparam [3:0] PH_SBRK  = 4'd1;
  localparam [3:0] PH_PREX  = 4'd2;
  localparam [3:0] PH_TRACK = 4'd3;
  localparam [3:0] PH_HOLD  = 4'd4;
  localparam [3:0] PH_RUN   = 4'd5;
  localparam [3:0] PH_DECEL = 4'd6;
  localparam [3:0] PH_WAIT  = 4'd7;
  localparam [3:0] PH_PBRK  = 4'd8;

  reg  [2:0]  ctrl_reg;
  reg  [1:0]  start_method_select;
  reg  [1:0]  speed_search_origin;
  reg  [6:0]  speed_search_rate;
  reg  [15:0] launch_frequency;
  reg  [9:0]  launch_hold_time;
  reg  [6:0]  start_brake_current;
  reg  [9:0]  start_brake_time;
  reg         stop_method_select;
  reg  [15:0] stop_brake_entry_frequency;
  reg  [9:0]  stop_brake_wait_time;
  reg  [6:0]  stop_brake_current;
  reg  [9:0]  stop_brake_time;
  reg  [15:0] target_reg;
  reg  [15:0] max_freq_reg;
  reg  [15:0] accel_step_reg;
  reg  [15:0] stop_freq_reg;
  reg  [3:0]  phase_reg;
  reg  [9:0]  ticks_reg;
  reg  [26:0] div_reg;
  reg         tick_reg;
  reg         last_rev_reg;
  reg         reversing_reg;
  // Remembers that the present run began as a jog, so that dropping the jog
  // bit still stops by ramp rather than by the configured stop method.
  reg         jog_run_reg;

  // A write lands at the edge that completes the transfer, where pready is
  // sampled high; a read loads prdata in the setup cycle so it stands early.
  wire        apb_wr = psel & penable & pwrite & pready;
  wire        apb_rd = psel & ~penable & ~pwrite;
  wire        run_cmd = ctrl_reg[`MSS_CTRL_RUN] | ctrl_reg[`MSS_CTRL_JOG];
  wire        jog = ctrl_reg[`MSS_CTRL_JOG];
  // Jog forces direct start and ramped stop regardless of settings.
  wire [1:0]  eff_start = jog ? `MSS_START_DIRECT : start_method_select;
  wire        eff_stop = jog_run_reg ? `MSS_STOP_DECEL : stop_method_select;
  // Larger rate gives a larger search step per tick.
  wire [15:0] search_step = {2'b00, speed_search_rate, 7'd0};
  // Distance between the command and the estimate, never negative.
  wire [15:0] delta = (out_freq > motor_speed_est) ? out_freq - motor_speed_est
                                                   : motor_speed_est - out_freq;

  // --------------------------------------------------------------------------
  // Tick generator
  // --------------------------------------------------------------------------
  // One enable pulse every 0.1 s; all phase timers step on it.
  // The divider runs free, so its phase is unrelated to commands and a timed
  // phase may end up to one tick earlier than its setting suggests.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg  <= 27'd0;
      tick_reg <= 1'b0;
    end else if (div_reg == TICK_CYC - 1) begin
      div_reg  <= 27'd0;
      tick_reg <= 1'b1;
    end else begin
      div_reg  <= div_reg + 27'd1;
      tick_reg <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------------
  // Writes clamp to the documented ranges so the sequencer never sees an
  // out-of-range time or current.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      ctrl_reg <= 3'd0;
      start_method_select <= `MSS_START_DIRECT;
      speed_search_origin <= `MSS_ORG_STOP;
      speed_search_rate <= `MSS_RST_RATE;
      launch_frequency <= 16'd0;
      launch_hold_time <= 10'd0;
      start_brake_current <= 7'd0;
      start_brake_time <= 10'd0;
      stop_method_select <= `MSS_STOP_DECEL;
      stop_brake_entry_frequency <= 16'd0;
      stop_brake_wait_time <= 10'd0;
      stop_brake_current <= 7'd0;
      stop_brake_time <= 10'd0;
      target_reg <= 16'd0;
      max_freq_reg <= `MSS_RST_MAXF;
      accel_step_reg <= 16'd1;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= 1'b0;
      // Reads decode in the setup cycle; the word then stands until the next read.
      if (apb_rd) begin
        case (paddr)
          `MSS_OFS_CTRL:   prdata <= {29'd0, ctrl_reg};
          `MSS_OFS_START:  prdata <= {16'd0, 1'b0, speed_search_rate, 4'd0,
                                      speed_search_origin, start_method_select};
          `MSS_OFS_HOLD:   prdata <= {6'd0, launch_hold_time, launch_frequency};
          `MSS_OFS_SBRK:   prdata <= {9'd0, start_brake_current, 6'd0, start_brake_time};
          `MSS_OFS_STOP:   prdata <= {15'd0, stop_method_select, stop_brake_entry_frequency};
          `MSS_OFS_PBRK:   prdata <= {1'b0, stop_brake_current, stop_brake_wait_time,
                                      4'd0, stop_brake_time};
          `MSS_OFS_TARGET: prdata <= {target_reg, accel_step_reg};
          `MSS_OFS_STATUS: prdata <= {23'd0, reversing_reg, out_enable, dc_inject,
                                      accel_enable, phase_reg, out_reverse};
          `MSS_OFS_FREQ:   prdata <= {max_freq_reg, out_freq};
          default:         prdata <= 32'h0000_0000;
        endcase
      end
      // Unmapped offsets answer with an error in the same cycle as pready.
      if (psel & penable & ~pready) begin
        case (paddr)
          `MSS_OFS_CTRL, `MSS_OFS_START, `MSS_OFS_HOLD, `MSS_OFS_SBRK, `MSS_OFS_STOP,
          `MSS_OFS_PBRK, `MSS_OFS_TARGET, `MSS_OFS_STATUS, `MSS_OFS_FREQ:
            pslverr <= 1'b0;
          default: pslverr <= 1'b1;
        endcase
      end
      // Out-of-range codes fall back to their defaults rather than to a spare
      // code; the start case would otherwise run an unknown method as a direct start.
      if (apb_wr) begin
        case (paddr)
          `MSS_OFS_CTRL: ctrl_reg <= pwdata[2:0];
          `MSS_OFS_START: begin
            start_method_select <= (pwdata[1:0] == 2'd3) ? 2'd0 : pwdata[1:0];
            speed_search_origin <= (pwdata[3:2] == 2'd3) ? 2'd0 : pwdata[3:2];
            speed_search_rate <= (pwdata[14:8] < `MSS_RATE_MIN) ? `MSS_RATE_MIN :
                                 (pwdata[14:8] > `MSS_RATE_MAX) ? `MSS_RATE_MAX :
                                 pwdata[14:8];
          end
          `MSS_OFS_HOLD: begin
            launch_frequency <= (pwdata[15:0] > `MSS_FREQ_LIM) ? `MSS_FREQ_LIM
                                                                : pwdata[15:0];
            launch_hold_time <= (pwdata[25:16] > `MSS_TIME_LIM) ? `MSS_TIME_LIM
                                                                 : pwdata[25:16];
          end
          `MSS_OFS_SBRK: begin
            start_brake_time <= (pwdata[9:0] > `MSS_TIME_LIM) ? `MSS_TIME_LIM
                                                               : pwdata[9:0];
            start_brake_current <= (pwdata[22:16] > `MSS_PCT_LIM) ? `MSS_PCT_LIM
                                                                   : pwdata[22:16];
          end
          `MSS_OFS_STOP: begin
            stop_brake_entry_frequency <= pwdata[15:0];
            stop_method_select <= pwdata[16];
          end
          `MSS_OFS_PBRK: begin
            stop_brake_time <= (pwdata[9:0] > `MSS_TIME_LIM) ? `MSS_TIME_LIM : pwdata[9:0];
            stop_brake_wait_time <= (pwdata[23:14] > `MSS_TIME_LIM) ? `MSS_TIME_LIM
                                                                     : pwdata[23:14];
            stop_brake_current <= (pwdata[30:24] > `MSS_PCT_LIM) ? `MSS_PCT_LIM
                                                                  : pwdata[30:24];
          end
          `MSS_OFS_TARGET: begin
            accel_step_reg <= (pwdata[15:0] == 16'd0) ? 16'd1 : pwdata[15:0];
            target_reg <= pwdata[31:16];
          end
          `MSS_OFS_FREQ: max_freq_reg <= pwdata[31:16];
          default: ;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Start and stop sequencer
  // --------------------------------------------------------------------------
  // A single phase register keeps the phases mutually exclusive.
  // Every drive-side output of the block is a flip-flop set in this process.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= PH_IDLE;
      ticks_reg <= 10'd0;
      out_freq <= 16'd0;
      out_reverse <= 1'b0;
      out_enable <= 1'b0;
      dc_inject <= 1'b0;
      inject_current <= 7'd0;
      accel_enable <= 1'b0;
      seq_time_count <= 1'b0;
      stop_freq_reg <= 16'd0;
      last_rev_reg <= 1'b0;
      reversing_reg <= 1'b0;
      jog_run_reg <= 1'b0;
    end else begin
      // The timer counts ticks in every phase but idle and a parked hold, which hold it at zero; a timed phase clears it on entry.
      if (tick_reg)
        ticks_reg <= ticks_reg + 10'd1;
      case (phase_reg)
        // Idle keeps every output but out_reverse and inject_current off; a run or jog command picks the start path.
        PH_IDLE: begin
          out_enable <= 1'b0;
          dc_inject <= 1'b0;
          accel_enable <= 1'b0;
          seq_time_count <= 1'b0;
          out_freq <= 16'd0;
          ticks_reg <= 10'd0;
          if (run_cmd) begin
            out_reverse <= ctrl_reg[`MSS_CTRL_REV];
            reversing_reg <= ctrl_reg[`MSS_CTRL_REV] != last_rev_reg;
            jog_run_reg <= jog;
            case (eff_start)
              `MSS_START_TRACK: begin
                phase_reg <= PH_TRACK;
                out_enable <= 1'b1;
                // A tracked start has no hold, so program time counts from here.
                seq_time_count <= 1'b1;
                case (speed_search_origin)
                  `MSS_ORG_ZERO: out_freq <= 16'd0;
                  `MSS_ORG_MAX:  out_freq <= max_freq_reg;
                  default:       out_freq <= stop_freq_reg;
                endcase
              end
              `MSS_START_PREEX: begin
                // Zero time skips field building entirely.
                phase_reg <= (start_brake_time == 10'd0) ? PH_HOLD : PH_PREX;
                dc_inject <= start_brake_time != 10'd0;
                inject_current <= start_brake_current;
              end
              default: begin
                phase_reg <= (start_brake_time == 10'd0) ? PH_HOLD : PH_SBRK;
                dc_inject <= start_brake_time != 10'd0;
                inject_current <= start_brake_current;
              end
            endcase
          end
        end
        // Start braking and pre-excitation share one timer and one current
        // setting; dropping the command abandons the start.
        PH_SBRK, PH_PREX: begin
          if (!run_cmd) begin
            phase_reg <= PH_IDLE;
          end else if (ticks_reg >= start_brake_time) begin
            dc_inject <= 1'b0;
            phase_reg <= PH_HOLD;
            ticks_reg <= 10'd0;
          end
        end
        // The search step is coarse, so lock comes within one step; the output then takes the estimate.
        PH_TRACK: begin
          // Step the output toward the motor estimate; lock when within a step.
          if (!run_cmd) begin
            phase_reg <= PH_IDLE;
          end else if (delta <= search_step) begin
            out_freq <= motor_speed_est;
            phase_reg <= PH_RUN;
          end else if (tick_reg) begin
            out_freq <= (out_freq > motor_speed_est) ? out_freq - search_step
                                                     : out_freq + search_step;
          end
        end
        // Holding keeps itself out of acceleration. A target below the launch
        // frequency parks the drive here with output off until the target rises.
        PH_HOLD: begin
          seq_time_count <= 1'b1;
          accel_enable <= 1'b0;
          if (!run_cmd) begin
            phase_reg <= PH_IDLE;
          end else if (target_reg < launch_frequency) begin
            out_enable <= 1'b0;
            out_freq <= 16'd0;
            ticks_reg <= 10'd0;
          end else begin
            out_enable <= 1'b1;
            out_freq <= launch_frequency;
            if (reversing_reg || ticks_reg >= launch_hold_time)
              phase_reg <= PH_RUN;
          end
        end
        // Running ramps by one step per clock toward the target. A stop either
        // hands over to deceleration or, for a coast stop, cuts output at once.
        PH_RUN: begin
          accel_enable <= 1'b1;
          out_enable <= 1'b1;
          if (!run_cmd) begin
            last_rev_reg <= out_reverse;
            stop_freq_reg <= out_freq;
            accel_enable <= 1'b0;
            if (eff_stop == `MSS_STOP_COAST) begin
              out_enable <= 1'b0;
              out_freq <= 16'd0;
              phase_reg <= PH_IDLE;
            end else begin
              phase_reg <= PH_DECEL;
            end
          end else if (out_freq < target_reg) begin
            out_freq <= (target_reg - out_freq > accel_step_reg) ? out_freq + accel_step_reg
                                                                  : target_reg;
          end else if (out_freq > target_reg) begin
            out_freq <= (out_freq - target_reg > accel_step_reg) ? out_freq - accel_step_reg
                                                                  : target_reg;
          end
        end
        // A fresh run command overturns deceleration. Reaching the entry
        // frequency turns the output off before any braking current flows,
        // which keeps injection away from a fast-spinning rotor.
        PH_DECEL: begin
          if (run_cmd) begin
            phase_reg <= PH_RUN;
          end else if (out_freq <= stop_brake_entry_frequency) begin
            out_enable <= 1'b0;
            ticks_reg <= 10'd0;
            phase_reg <= (stop_brake_time == 10'd0) ? PH_IDLE : PH_WAIT;
            stop_freq_reg <= out_freq;
            out_freq <= 16'd0;
          end else begin
            out_freq <= (out_freq > accel_step_reg) ? out_freq - accel_step_reg
                                                    : 16'd0;
          end
        end
        // The gap lets the rotor field decay before injection begins.
        PH_WAIT: begin
          if (ticks_reg >= stop_brake_wait_time) begin
            phase_reg <= PH_PBRK;
            ticks_reg <= 10'd0;
            dc_inject <= 1'b1;
            inject_current <= stop_brake_current;
          end
        end
        // Stop braking is not cut short by a new command; a pending run
        // restarts from idle once the braking time has passed.
        PH_PBRK: begin
          if (ticks_reg >= stop_brake_time) begin
            dc_inject <= 1'b0;
            phase_reg <= PH_IDLE;
          end
        end
        default: phase_reg <= PH_IDLE;
      endcase
    end
  end
endmodule // mss_sequencer
`default_nettype wire

// ---- verification/mss_motor_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Motor seen through the speed estimator
// ----------------------------------------
module mss_motor_model #(
  parameter logic [15:0] INIT_SPEED = 16'h0BB8
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [15:0] out_freq,
  input  wire logic        out_enable,
  input  wire logic        dc_inject,
  output var  logic [15:0] motor_speed_est
);
  // The rotor slows under injection and creeps toward the drive frequency.
  // A coasting rotor keeps its speed, so tracking always has something to find.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      motor_speed_est <= INIT_SPEED;
    end else if (dc_inject && motor_speed_est != 16'h0000) begin
      motor_speed_est <= motor_speed_est - 16'h0001;
    end else if (out_enable && motor_speed_est < out_freq) begin
      motor_speed_est <= motor_speed_est + 16'h0001;
    end else if (out_enable && motor_speed_est > out_freq) begin
      motor_speed_est <= motor_speed_est - 16'h0001;
    end
  end
endmodule // mss_motor_model
`default_nettype wire

// ---- verification/mss_sequencer_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checks for the sequencer
// ----------------------------------------
module mss_seq_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [15:0] out_freq,
  input wire logic        out_enable,
  input wire logic        dc_inject,
  input wire logic [6:0]  inject_current,
  input wire logic        accel_enable,
  input wire logic        seq_time_count
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A setup edge followed by the first access edge.
  sequence s_setup_access;
    psel && !penable ##1 psel && penable;
  endsequence
  property p_ready_latency;
    s_setup_access |=> pready;
  endproperty
  a_ready_latency: assert property (p_ready_latency) else $error("pready late");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("lone pslverr");
  property p_reset_idle;
    $rose(presetn) |-> !out_enable && !dc_inject && out_freq == 16'h0000;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("busy after reset");
  // Injection never overlaps a rotating field; it would fight the braking current.
  property p_inject_no_freq;
    dc_inject |-> out_freq == 16'h0000;
  endproperty
  a_inject_no_freq: assert property (p_inject_no_freq) else $error("freq in dc");
  property p_off_no_freq;
    !out_enable |-> out_freq == 16'h0000;
  endproperty
  a_off_no_freq: assert property (p_off_no_freq) else $error("freq when off");
  property p_inject_pct;
    dc_inject |-> inject_current <= 7'd100;
  endproperty
  a_inject_pct: assert property (p_inject_pct) else $error("current over 100");
  property p_hold_counted;
    out_enable && !accel_enable && !dc_inject && out_freq != 16'h0000 |-> seq_time_count;
  endproperty
  a_hold_counted: assert property (p_hold_counted) else $error("hold not counted");
endmodule // mss_seq_checker
bind mss_sequencer mss_seq_checker u_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .out_freq(out_freq),
  .out_enable(out_enable), .dc_inject(dc_inject), .inject_current(inject_current),
  .accel_enable(accel_enable), .seq_time_count(seq_time_count));
`default_nettype wire

// ---- verification/mss_sequencer_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "mss_map.vh"
module mss_sequencer_bench;
  // ----------------------------------------
  // Stimulus, observation and bookkeeping
  // ----------------------------------------
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] q;
  logic        e;
  logic        seen;
  logic [16:0] d;
  wire  [31:0] prdata;
  wire  [15:0] out_freq, motor_speed_est;
  wire  [6:0]  inject_current;
  wire         pready, pslverr, out_reverse, out_enable, dc_inject, accel_enable, seq_time_count;
  int          n_errors = 0, samples_checked = 0, i, n;
  logic [31:0] t_start [5] = '{32'h0000_1400, 32'h0000_1400, 32'h0000_1402, 32'h0000_1402,
                               32'h0000_1409};
  logic [31:0] t_sbrk [5]  = '{32'h0000_0000, 32'h001E_0002, 32'h0019_0002, 32'h0000_0000,
                               32'h0019_0002};
  logic [6:0]  t_pct [5]   = '{7'h00, 7'h1E, 7'h19, 7'h00, 7'h19};
  // Clock of 100 MHz.
  always #5 pclk = ~pclk;
  // A ten-cycle tick keeps every timed phase short.
  mss_sequencer #(.TICK_CYC(10)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .motor_speed_est(motor_speed_est),
    .out_freq(out_freq), .out_reverse(out_reverse), .out_enable(out_enable),
    .dc_inject(dc_inject), .inject_current(inject_current), .accel_enable(accel_enable),
    .seq_time_count(seq_time_count));
  mss_motor_model u_motor (.pclk(pclk), .presetn(presetn), .out_freq(out_freq),
    .out_enable(out_enable), .dc_inject(dc_inject), .motor_speed_est(motor_speed_est));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One transfer; the request stands until pready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Outputs are sampled 1 ns after the edge so their updates have landed.
  task automatic tk;
    @(posedge pclk);
    #1;
  endtask
  task automatic coast;
    apb(1'b1, `MSS_OFS_STOP, 32'h0001_0000);
    apb(1'b1, `MSS_OFS_CTRL, 32'h0000_0000);
    repeat (3) tk;
    chk({out_enable, out_freq}, 32'h0000_0000);
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Watchdog at 20,000 cycles, several times the expected run length.
  initial begin
    #200_000;
    n_errors++;
    conclude;
  end
  // Main sequence.
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `MSS_OFS_START, 32'h0000_0000);
    chk(q, 32'h0000_1400);
    apb(1'b0, `MSS_OFS_FREQ, 32'h0000_0000);
    chk(q, 32'h1388_0000);
    apb(1'b1, 12'h100, 32'h0000_0001);
    chk(e, 1'b1);
    apb(1'b0, 12'h100, 32'h0000_0000);
    chk({e, q}, {1'b1, 32'h0000_0000});
    apb(1'b1, `MSS_OFS_HOLD, 32'h0003_01F4);
    apb(1'b1, `MSS_OFS_TARGET, 32'h07D0_000A);
    apb(1'b1, `MSS_OFS_SBRK, 32'h0019_0002);
    $display("register test done");
    // Tracking from zero speed must lock near the spinning rotor, with no braking.
    apb(1'b1, `MSS_OFS_START, 32'h0000_1405);
    apb(1'b1, `MSS_OFS_CTRL, 32'h0000_0001);
    for (i = 0; i < 20000 && accel_enable !== 1'b1; i++) tk;
    d = (out_freq > motor_speed_est) ? out_freq - motor_speed_est : motor_speed_est - out_freq;
    chk({d <= 17'd2560, out_freq != 16'h0000, dc_inject}, 3'b110);
    coast;
    $display("tracking test done");
    // Direct and pre-excitation starts with and without injection, then a jog that ignores the stop mode.
    for (n = 0; n < 5; n++) begin
      apb(1'b1, `MSS_OFS_START, t_start[n]);
      apb(1'b1, `MSS_OFS_SBRK, t_sbrk[n]);
      apb(1'b1, `MSS_OFS_CTRL, (n == 4) ? 32'h0000_0002 : 32'h0000_0001);
      for (i = 0; i < 3000 && dc_inject !== 1'b1 && out_freq === 16'h0000; i++) tk;
      chk({dc_inject, inject_current}, {t_pct[n] != 7'h00, t_pct[n]});
      for (i = 0; i < 3000 && out_freq === 16'h0000; i++) tk;
      chk({out_freq, dc_inject, accel_enable, seq_time_count}, {16'd500, 3'b001});
      for (i = 0; i < 100 && accel_enable !== 1'b1; i++) tk;
      chk(i >= 20 && i <= 31, 1'b1);
      if (n == 4) begin
        apb(1'b1, `MSS_OFS_STOP, 32'h0001_0000);
        apb(1'b1, `MSS_OFS_CTRL, 32'h0000_0000);
        repeat (3) tk;
        chk(out_enable, 1'b1);
        for (i = 0; i < 3000 && out_enable !== 1'b0; i++) tk;
      end else begin
        coast;
      end
      $display("start case %0d done", n);
    end
    // Ramp down through the entry point, wait with output off, then brake.
    apb(1'b1, `MSS_OFS_START, 32'h0000_1400);
    apb(1'b1, `MSS_OFS_SBRK, 32'h0000_0000);
    apb(1'b1, `MSS_OFS_CTRL, 32'h0000_0001);
    for (i = 0; i < 3000 && out_freq !== 16'd2000; i++) tk;
    apb(1'b1, `MSS_OFS_STOP, 32'h0000_012C);
    apb(1'b1, `MSS_OFS_PBRK, 32'h2800_8002);
    apb(1'b1, `MSS_OFS_CTRL, 32'h0000_0000);
    tk;
    chk(out_enable, 1'b1);
    seen = 1'b0;
    for (i = 0; i < 3000 && dc_inject !== 1'b1; i++) begin
      tk;
      seen = seen | (out_enable === 1'b0);
    end
    chk({seen, inject_current, out_freq}, {1'b1, 7'd40, 16'd0});
    for (i = 0; i < 3000 && dc_inject !== 1'b0; i++) tk;
    chk({dc_inject, out_enable}, 2'b00);
    $display("stop braking test done");
    // A target under the launch frequency leaves the drive holding with no output.
    apb(1'b1, `MSS_OFS_PBRK, 32'h0000_0000);
    apb(1'b1, `MSS_OFS_TARGET, 32'h00C8_000A);
    apb(1'b1, `MSS_OFS_CTRL, 32'h0000_0001);
    repeat (40) tk;
    chk({out_enable, out_freq}, 17'h0_0000);
    apb(1'b1, `MSS_OFS_CTRL, 32'h0000_0000);
    $display("low target test done");
    // A reverse start right after a forward run skips the hold time.
    apb(1'b1, `MSS_OFS_TARGET, 32'h07D0_000A);
    apb(1'b1, `MSS_OFS_CTRL, 32'h0000_0005);
    for (i = 0; i < 100 && accel_enable !== 1'b1; i++) tk;
    chk({out_reverse, i < 20}, 2'b11);
    apb(1'b1, `MSS_OFS_CTRL, 32'h0000_0000);
    $display("reverse test done");
    conclude;
  end
endmodule // mss_sequencer_bench
`default_nettype wire
